// >>> logic/dsr_pkg.sv
package dsr_pkg;

  // ----------------------------------------------------------------
  // Memory types and channel configuration
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MEM_INT    = 2'h0,
    MEM_ASYNC  = 2'h1,
    MEM_SDRAM  = 2'h2,
    MEM_SBSRAM = 2'h3
  } dsr_mem_t;

  typedef struct packed {
    dsr_mem_t    src_mem;
    dsr_mem_t    dst_mem;
    logic        same_res;   // Source and destination share one resource
    logic [1:0]  rd_hold;    // Read hold setting of asynchronous memory
    logic [15:0] elem_cnt;   // Elements per frame, at least one
    logic [7:0]  frame_cnt;  // Frames per block, at least one
  } dsr_cfg_t;

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_LAT     = 4'h1,
    ST_SWITCH  = 4'h2,
    ST_SETUP   = 4'h3,
    ST_READ    = 4'h4,
    ST_HOLD    = 4'h5,
    ST_TURN_RW = 4'h6,
    ST_WRITE   = 4'h7,
    ST_TURN_WR = 4'h8,
    ST_GAP     = 4'h9,
    ST_DRAIN   = 4'ha,
    ST_FIN     = 4'hb
  } dsr_state_t;

  // ----------------------------------------------------------------
  // Start field and read hold codes
  // ----------------------------------------------------------------
  localparam logic [1:0] START_RUN      = 2'h1;
  localparam logic [1:0] READ_HOLD_SLOW = 2'h3;

  // ----------------------------------------------------------------
  // Shared resource burst sizes, in elements
  // ----------------------------------------------------------------
  localparam logic [7:0] BURST_INT        = 8'h05;
  localparam logic [7:0] BURST_ASYNC      = 8'h03;
  localparam logic [7:0] BURST_ASYNC_SLOW = 8'h02;
  localparam logic [7:0] BURST_SDRAM      = 8'h06;
  localparam logic [7:0] BURST_SBSRAM     = 8'h05;

  // ----------------------------------------------------------------
  // Timing counts, CPU clock cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] LAT_INT         = 8'h02;
  localparam logic [7:0] LAT_ASYNC       = 8'h09;
  localparam logic [7:0] LAT_SDRAM       = 8'h0c;
  localparam logic [7:0] LAT_SBSRAM      = 8'h0b;
  localparam logic [7:0] SETUP_SBSRAM    = 8'h04;
  localparam logic [7:0] HOLD_SBSRAM     = 8'h04;
  localparam logic [7:0] SETUP_OTHER     = 8'h01;
  localparam logic [7:0] HOLD_OTHER      = 8'h01;
  localparam logic [7:0] GAP_ASYNC       = 8'h01;
  localparam logic [7:0] GAP_SDRAM       = 8'h10;
  localparam logic [7:0] GAP_SBSRAM      = 8'h04;
  localparam logic [7:0] GAP_INT         = 8'h01;
  localparam logic [7:0] EPC_SBSRAM      = 8'h02;
  localparam logic [7:0] EPC_OTHER       = 8'h01;
  localparam logic [7:0] TURN_RW_INT     = 8'h08;
  localparam logic [7:0] TURN_WR_INT     = 8'h09;
  localparam logic [7:0] EXT_BASE_SW     = 8'h02;
  localparam logic [7:0] EXT_RD2WR_EXTRA = 8'h04;
  localparam logic [7:0] EXT_WR2RD_EXTRA = 8'h04;
  localparam logic [7:0] SW_SBS_RD2WR    = 8'h06;
  localparam logic [7:0] SW_HP_RD_LP_WR  = 8'h0f;

endpackage

// >>> logic/dsr_fifo.sv
`timescale 1ns/10ps
module dsr_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       sys_rst_in,
  // Fill side
  input  wire logic                       in_valid_in,
  input  wire logic [W-1:0]               in_data_in,
  output logic                            in_ready_out,
  // Drain side
  output logic                            out_valid_out,
  output logic [W-1:0]                    out_data_out,
  input  wire logic                       out_ready_in,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]      count_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic          push;
  logic          pop;

  // Handshakes; ready never looks at valid
  assign in_ready_out  = (count_ff != CW'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;
  assign out_data_out  = mem_ff[rd_ptr_ff];
  assign count_out     = count_ff;

  // Storage, no reset needed on data
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // Pointers wrap explicitly so any depth works
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_ff <= '0;
    end else if (push && !pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (pop && !push) begin
      count_ff <= count_ff - 1'b1;
    end
  end

endmodule

// >>> logic/dsr_engine.sv
// Function
// - Never read and write shared resource together
// - Pending writes beat pending reads
// - Separate resources write while holding buffer holds data
// - Burst size set by read memory type
// - Slow asynchronous read hold gives two-element bursts
// - External turnarounds add four cycles each way
// - Internal turnarounds take eight and nine cycles
// - Internal element access takes one cycle
// - Sync flag sets one cycle after start
// - Half-rate burst read begins eleven cycles later
// - Four setup and four hold cycles
// - Four idle cycles between frame bursts
// - Every frame ends its own burst
// - Read-to-write channel switch costs 6+15 cycles
// - Later channel waits for running transfer
// - Lowest-numbered pending channel wins
`timescale 1ns/10ps
module dsr_engine
  import dsr_pkg::*;
#(
  parameter int NCH   = 4,
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   sys_rst_in,
  // Channel start writes and configuration
  input  wire logic                   start_wr_in,
  input  wire logic [$clog2(NCH)-1:0] start_chan_in,
  input  wire logic [1:0]             start_field_in,
  input  dsr_cfg_t                    chan_cfg_in [NCH],
  // Memory read port
  output logic                        mem_rd_strobe_out,
  output logic [$clog2(NCH)-1:0]      mem_rd_chan_out,
  input  wire logic [W-1:0]           mem_rd_data_in,
  // Memory write port
  output logic                        mem_wr_strobe_out,
  output logic [W-1:0]                mem_wr_data_out,
  input  wire logic                   mem_wr_ready_in,
  // Status
  output logic [NCH-1:0]              read_sync_flag_out,
  output logic [NCH-1:0]              chan_done_out,
  output logic                        chan_busy_out
);

  localparam int CW = $clog2(NCH);
  localparam int FW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // Memory type lookups
  // ----------------------------------------------------------------
  function automatic logic [7:0] lat_of(input dsr_mem_t m);
    unique case (m)
      MEM_INT:   lat_of = LAT_INT;
      MEM_ASYNC: lat_of = LAT_ASYNC;
      MEM_SDRAM: lat_of = LAT_SDRAM;
      MEM_SBSRAM: lat_of = LAT_SBSRAM;
    endcase
  endfunction

  function automatic logic [7:0] gap_of(input dsr_mem_t m);
    unique case (m)
      MEM_INT:   gap_of = GAP_INT;
      MEM_ASYNC: gap_of = GAP_ASYNC;
      MEM_SDRAM: gap_of = GAP_SDRAM;
      MEM_SBSRAM: gap_of = GAP_SBSRAM;
    endcase
  endfunction

  function automatic logic [7:0] burst_of(input dsr_cfg_t c);
    unique case (c.src_mem)
      MEM_INT:   burst_of = BURST_INT;
      MEM_ASYNC: burst_of = (c.rd_hold == READ_HOLD_SLOW) ? BURST_ASYNC_SLOW : BURST_ASYNC;
      MEM_SDRAM: burst_of = BURST_SDRAM;
      MEM_SBSRAM: burst_of = BURST_SBSRAM;
    endcase
  endfunction

  // Strobe-to-strobe internal figures less hold and setup cycles
  function automatic logic [7:0] turn_of(input dsr_cfg_t c, input logic to_wr);
    if (c.src_mem == MEM_INT && c.dst_mem == MEM_INT) begin
      turn_of = to_wr ? TURN_RW_INT - 8'h02 : TURN_WR_INT - 8'h02;
    end else begin
      turn_of = EXT_BASE_SW + (to_wr ? EXT_RD2WR_EXTRA : EXT_WR2RD_EXTRA);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dsr_state_t     st_ff;
  dsr_state_t     nxt_state;
  logic [7:0]     cnt_ff;
  logic [7:0]     nxt_cnt;
  dsr_cfg_t       cfg_ff;
  logic [CW-1:0]  cur_ff;
  logic [NCH-1:0] flag_ff;
  logic [NCH-1:0] done_ff;
  logic [15:0]    elem_left_ff;
  logic [7:0]     frame_left_ff;
  logic [7:0]     burst_ff;
  logic [7:0]     sub_ff;
  logic           done_rd_ff;
  logic           fend_ff;
  logic           prev_ok_ff;
  logic           prev_sbs_rd_ff;
  logic           sel_found;
  logic [CW-1:0]  sel_idx;
  logic           rd_go;
  logic           rd_end;
  logic           last_elem;
  logic           wr_win;
  logic           wr_go;
  logic           wr_empty;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic [FW-1:0]  fifo_count;
  logic [7:0]     setup_cyc;
  logic [7:0]     hold_cyc;
  logic [7:0]     epc;

  // Burst shape of the current source
  assign setup_cyc = (cfg_ff.src_mem == MEM_SBSRAM) ? SETUP_SBSRAM : SETUP_OTHER;
  assign hold_cyc  = (cfg_ff.src_mem == MEM_SBSRAM) ? HOLD_SBSRAM : HOLD_OTHER;
  assign epc       = (cfg_ff.src_mem == MEM_SBSRAM) ? EPC_SBSRAM : EPC_OTHER;

  always_comb begin
    sel_found = 1'b0;
    sel_idx   = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (flag_ff[i]) begin
        sel_found = 1'b1;
        sel_idx   = CW'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Port arbitration
  // ----------------------------------------------------------------
  // separate resources drain whenever data is held; a shared one only in ST_WRITE
  assign wr_win = cfg_ff.same_res ? (st_ff == ST_WRITE) : (st_ff != ST_IDLE && st_ff != ST_FIN);
  assign wr_go  = fifo_out_valid && mem_wr_ready_in && wr_win;
  // read yields to a write on the shared resource
  assign rd_go  = (st_ff == ST_READ) && (sub_ff == epc - 8'h01) && fifo_in_ready
                  && !(cfg_ff.same_res && wr_go);
  assign last_elem = (elem_left_ff == 16'h0001);
  assign rd_end = rd_go && (last_elem
                  || (cfg_ff.same_res && burst_ff == burst_of(cfg_ff) - 8'h01));
  assign wr_empty = !fifo_out_valid || (wr_go && fifo_count == FW'(1));

  assign mem_rd_strobe_out  = rd_go;
  assign mem_wr_strobe_out  = wr_go;
  assign mem_rd_chan_out    = cur_ff;
  assign read_sync_flag_out = flag_ff;
  assign chan_done_out      = done_ff;
  assign chan_busy_out      = (st_ff != ST_IDLE);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = st_ff;
    nxt_cnt   = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
    unique case (st_ff)
      ST_IDLE: begin
        // queued channel follows the finished one
        if (sel_found && prev_ok_ff) begin
          nxt_state = ST_SWITCH;
          // burst read to burst write switch
          if (prev_sbs_rd_ff && chan_cfg_in[sel_idx].dst_mem == MEM_SBSRAM) begin
            nxt_cnt = SW_SBS_RD2WR + SW_HP_RD_LP_WR - 8'h01;
          end else begin
            nxt_cnt = EXT_BASE_SW - 8'h01;
          end
        end else if (sel_found) begin
          nxt_state = ST_LAT;
          nxt_cnt   = lat_of(chan_cfg_in[sel_idx].src_mem) - 8'h02;
        end
      end
      ST_LAT, ST_SWITCH, ST_GAP: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_SETUP;
          nxt_cnt   = setup_cyc - 8'h01;
        end
      end
      ST_SETUP: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_READ;
        end
      end
      ST_READ: begin
        if (rd_end) begin
          nxt_state = ST_HOLD;
          nxt_cnt   = hold_cyc - 8'h01;
        end
      end
      ST_HOLD: begin
        if (cnt_ff == 8'h00) begin
          if (cfg_ff.same_res) begin
            nxt_state = ST_TURN_RW;
            nxt_cnt   = turn_of(cfg_ff, 1'b1) - 8'h01;
          end else if (done_rd_ff) begin
            nxt_state = ST_DRAIN;
          end else begin
            nxt_state = ST_GAP;
            nxt_cnt   = gap_of(cfg_ff.src_mem) - 8'h01;
          end
        end
      end
      ST_TURN_RW: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (wr_empty) begin
          nxt_state = done_rd_ff ? ST_FIN : ST_TURN_WR;
          nxt_cnt   = turn_of(cfg_ff, 1'b0) - 8'h01;
        end
      end
      ST_TURN_WR: begin
        if (cnt_ff == 8'h00 && fend_ff) begin
          nxt_state = ST_GAP;
          nxt_cnt   = gap_of(cfg_ff.src_mem) - 8'h01;
        end else if (cnt_ff == 8'h00) begin
          nxt_state = ST_SETUP;
          nxt_cnt   = setup_cyc - 8'h01;
        end
      end
      ST_DRAIN: begin
        if (!fifo_out_valid) begin
          nxt_state = ST_FIN;
        end
      end
      ST_FIN: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_ff  <= ST_IDLE;
      cnt_ff <= 8'h00;
    end else begin
      st_ff  <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Channel capture; held for the whole transfer
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cur_ff <= '0;
      cfg_ff <= '0;
    end else if (st_ff == ST_IDLE && sel_found) begin
      cur_ff <= sel_idx;
      cfg_ff <= chan_cfg_in[sel_idx];
    end
  end

  // flag one cycle after start; set beats clear
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flag_ff <= '0;
      done_ff <= '0;
    end else begin
      done_ff <= '0;
      for (int i = 0; i < NCH; i++) begin
        if (start_wr_in && start_field_in == START_RUN && start_chan_in == CW'(i)) begin
          flag_ff[i] <= 1'b1;
        end else if (st_ff == ST_FIN && cur_ff == CW'(i)) begin
          flag_ff[i] <= 1'b0;
        end
        if (st_ff == ST_FIN && cur_ff == CW'(i)) begin
          done_ff[i] <= 1'b1;
        end
      end
    end
  end

  // Element, frame and block accounting
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      elem_left_ff  <= 16'h0000;
      frame_left_ff <= 8'h00;
      done_rd_ff    <= 1'b0;
      fend_ff       <= 1'b0;
    end else if (st_ff == ST_IDLE && sel_found) begin
      elem_left_ff  <= chan_cfg_in[sel_idx].elem_cnt;
      frame_left_ff <= chan_cfg_in[sel_idx].frame_cnt - 8'h01;
      done_rd_ff    <= 1'b0;
      fend_ff       <= 1'b0;
    end else if (st_ff == ST_SETUP) begin
      fend_ff <= 1'b0;
    end else if (rd_go && last_elem) begin
      elem_left_ff <= cfg_ff.elem_cnt;
      fend_ff      <= 1'b1;
      if (frame_left_ff == 8'h00) begin
        done_rd_ff <= 1'b1;
      end else begin
        frame_left_ff <= frame_left_ff - 8'h01;
      end
    end else if (rd_go) begin
      elem_left_ff <= elem_left_ff - 16'h0001;
    end
  end

  // Burst length and half-rate element phase
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      burst_ff <= 8'h00;
      sub_ff   <= 8'h00;
    end else begin
      if (st_ff == ST_SETUP) begin
        burst_ff <= 8'h00;
      end else if (rd_go) begin
        burst_ff <= burst_ff + 8'h01;
      end
      // Phase stalls on its last step while the buffer is full
      if (st_ff != ST_READ || rd_go) begin
        sub_ff <= 8'h00;
      end else if (sub_ff != epc - 8'h01) begin
        sub_ff <= sub_ff + 8'h01;
      end
    end
  end

  // Memory of the previous channel, for switch timing
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_ok_ff     <= 1'b0;
      prev_sbs_rd_ff <= 1'b0;
    end else if (st_ff == ST_FIN) begin
      prev_ok_ff     <= 1'b1;
      prev_sbs_rd_ff <= (cfg_ff.src_mem == MEM_SBSRAM);
    end else if (st_ff == ST_IDLE) begin
      prev_ok_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Holding buffer between read and write ports
  // ----------------------------------------------------------------
  dsr_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (rd_go),
    .in_data_in    (mem_rd_data_in),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (mem_wr_data_out),
    .out_ready_in  (wr_go),
    .count_out     (fifo_count)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dflt_cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  chk_no_rdwr_same:
    assert property ((cfg_ff.same_res && mem_rd_strobe_out) |-> !mem_wr_strobe_out)
    else $error("read and write together on shared resource");
  chk_wr_over_rd:
    assert property ((cfg_ff.same_res && st_ff == ST_WRITE) |-> !mem_rd_strobe_out)
    else $error("read issued while writes pending");
  chk_drain_held:
    assert property ((!cfg_ff.same_res && st_ff == ST_DRAIN && fifo_out_valid
                      && mem_wr_ready_in) |-> mem_wr_strobe_out)
    else $error("held element not written");
  chk_burst_size:
    assert property ((cfg_ff.same_res && mem_rd_strobe_out) |-> burst_ff < burst_of(cfg_ff))
    else $error("shared resource burst too long");
  chk_slow_burst:
    assert property ((cfg_ff.same_res && cfg_ff.src_mem == MEM_ASYNC
                      && cfg_ff.rd_hold == READ_HOLD_SLOW && mem_rd_strobe_out)
                     |-> burst_ff < 8'h02)
    else $error("slow asynchronous burst above two");
  chk_int_turn_rw:
    assert property ((rd_end && cfg_ff.same_res && cfg_ff.src_mem == MEM_INT
                      && cfg_ff.dst_mem == MEM_INT)
                     |-> ##1 (!mem_wr_strobe_out)[*7] ##1 (mem_wr_strobe_out || !mem_wr_ready_in))
    else $error("internal read to write turnaround not 8");
  chk_sync_flag:
    assert property ((start_wr_in && start_field_in == START_RUN)
                     |=> read_sync_flag_out[$past(start_chan_in)])
    else $error("sync flag not set one cycle after start");
  chk_sbs_start:
    assert property ((st_ff == ST_IDLE && nxt_state == ST_LAT
                      && chan_cfg_in[sel_idx].src_mem == MEM_SBSRAM) |-> ##11 st_ff == ST_SETUP)
    else $error("burst read not begun 11 cycles after flag");
  chk_sbs_setup:
    assert property (($rose(st_ff == ST_SETUP) && cfg_ff.src_mem == MEM_SBSRAM)
                     |-> (st_ff == ST_SETUP)[*4] ##1 st_ff == ST_READ)
    else $error("burst read setup not 4 cycles");
  chk_sbs_gap:
    assert property (($rose(st_ff == ST_GAP) && cfg_ff.src_mem == MEM_SBSRAM)
                     |-> (st_ff == ST_GAP)[*4] ##1 st_ff == ST_SETUP)
    else $error("frame gap not 4 cycles");
  chk_frame_end:
    assert property ((mem_rd_strobe_out && last_elem) |-> nxt_state == ST_HOLD)
    else $error("burst ran past frame boundary");
  chk_switch_gap:
    assert property ((st_ff == ST_IDLE && nxt_state == ST_SWITCH && prev_sbs_rd_ff
                      && chan_cfg_in[sel_idx].dst_mem == MEM_SBSRAM) |-> ##22 st_ff == ST_SETUP)
    else $error("channel switch not 21 cycles");
  chk_chan_hold:
    assert property ((st_ff != ST_IDLE) |=> $stable(cur_ff))
    else $error("channel changed mid transfer");
  chk_low_first:
    assert property ((st_ff == ST_IDLE && read_sync_flag_out[0]) |=> cur_ff == '0)
    else $error("lowest channel not granted");

  cov_same_int: cover property (rd_end && cfg_ff.same_res && cfg_ff.src_mem == MEM_INT);
  cov_frame_gap: cover property ($rose(st_ff == ST_GAP) && cfg_ff.src_mem == MEM_SBSRAM);
  cov_switch: cover property (st_ff == ST_IDLE && nxt_state == ST_SWITCH);
  cov_full: cover property (st_ff == ST_READ && !fifo_in_ready);

endmodule

// >>> tb/dsr_mem_model.sv
`timescale 1ns/10ps
module dsr_mem_model (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  // Engine side
  input  wire logic        rd_strobe_in,
  output logic [31:0]      rd_data_out,
  input  wire logic        stall_in,
  output logic             wr_ready_out
);
  logic [31:0] cnt_ff;
  // Data only valid in the strobe cycle; inverted otherwise to expose late sampling
  // one element per cycle
  assign rd_data_out  = rd_strobe_in ? cnt_ff : ~cnt_ff;
  assign wr_ready_out = ~stall_in;
  // Element counter, one step per read
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_ff <= 32'h0000_0000;
    end else if (rd_strobe_in) begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end
endmodule

// >>> tb/dsr_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module testbench
  import dsr_pkg::*;
;
  typedef struct {dsr_mem_t m; logic [1:0] h; logic [15:0] e; logic [7:0] f;
    int b; int t; int w;} dsr_row_t;
  logic mclk_in, sys_rst_in, start_wr_in, stall, rd_s, wr_s, rdy, busy, seen;
  logic [1:0] s_ch, s_fld, rd_ch;
  logic [31:0] rd_d, wr_d, exp_d;
  logic [3:0] flag, done;
  dsr_cfg_t cfg [4];
  int fails, total_checks, nrd, nwr, fb, lr, lw, g_rw, g_wr, cyc, i, sv;
  // Same-resource rows: memory, hold, elements, frames, burst, read-write gap, write-read gap
  // first row frame is a burst multiple
  dsr_row_t rows [5] = '{'{MEM_INT, 0, 10, 2, 5, 8, 9}, '{MEM_ASYNC, 0, 7, 1, 3, 8, 8},
    '{MEM_ASYNC, 3, 7, 1, 2, 8, 8}, '{MEM_SDRAM, 0, 7, 1, 6, 8, 8},
    '{MEM_SBSRAM, 0, 7, 1, 5, 11, 12}};
  dsr_engine dsr_engine_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .start_wr_in(start_wr_in), .start_chan_in(s_ch), .start_field_in(s_fld),
    .chan_cfg_in(cfg), .mem_rd_strobe_out(rd_s), .mem_rd_chan_out(rd_ch),
    .mem_rd_data_in(rd_d), .mem_wr_strobe_out(wr_s), .mem_wr_data_out(wr_d),
    .mem_wr_ready_in(rdy), .read_sync_flag_out(flag), .chan_done_out(done),
    .chan_busy_out(busy));
  dsr_mem_model dsr_mem_model_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .rd_strobe_in(rd_s), .rd_data_out(rd_d), .stall_in(stall), .wr_ready_out(rdy));
  // Clock, 40 ns period
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // Port monitor: overlap, data order, burst length and turnaround gaps
  always @(posedge mclk_in) begin
    cyc++;
    // Separate resources may read and write together; only a shared one may not
    if ((rd_s | wr_s) && cfg[rd_ch].same_res) `CHK(rd_s & wr_s, 1'b0)
    if (rd_s) begin
      if (seen && g_wr < 0) g_wr = cyc - lw;
      if (!seen) fb++;
      nrd++;
      lr = cyc;
    end
    if (wr_s) begin
      `CHK({wr_d, stall}, {exp_d, 1'b0})
      if (!seen) g_rw = cyc - lr;
      exp_d++;
      seen = 1'b1;
      nwr++;
      lw = cyc;
    end
  end
  task automatic clr();
    {nrd, nwr, fb, g_rw, g_wr, seen} = {32'd0, 32'd0, 32'd0, 32'd0, -32'sd1, 1'b0};
  endtask
  task automatic start(input logic [1:0] ch, input logic [1:0] fld);
    @(negedge mclk_in) {start_wr_in, s_ch, s_fld} = {1'b1, ch, fld};
    @(negedge mclk_in) start_wr_in = 1'b0;
  endtask
  task automatic wait_done(input int ch);
    for (i = 0; i < 4000 && done[ch] !== 1'b1; i++) @(negedge mclk_in);
    if (i == 4000) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {sys_rst_in, start_wr_in, stall, s_ch, s_fld, exp_d, cyc} = '0;
    sys_rst_in = 1'b1;
    for (i = 0; i < 4; i++) cfg[i] = '{MEM_INT, MEM_INT, 1'b0, 2'h0, 16'h0002, 8'h01};
    clr();
    repeat (2) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    `CHK({busy, flag, done}, 9'h000)
    // Start codes other than run are ignored
    for (sv = 0; sv < 4; sv++) if (sv != 1) begin
      start(2'h1, sv[1:0]);
      `CHK(flag[1], 1'b0)
    end
    foreach (rows[r]) begin
      cfg[0] = '{rows[r].m, rows[r].m, 1'b1, rows[r].h, rows[r].e, rows[r].f};
      clr();
      start(2'h0, START_RUN);
      `CHK(flag[0], 1'b1)
      wait_done(0);
      `CHK(fb, rows[r].b)
      `CHK({g_rw, g_wr}, {rows[r].t, rows[r].w})
      `CHK(nwr, int'(rows[r].e) * rows[r].f)
    end
    // Write port stalled: buffer fills, reads stop, then drains
    cfg[0] = '{MEM_INT, MEM_SDRAM, 1'b0, 2'h0, 16'h0028, 8'h01};
    clr();
    stall = 1'b1;
    start(2'h0, START_RUN);
    repeat (60) @(negedge mclk_in);
    sv = nrd;
    repeat (10) @(negedge mclk_in);
    `CHK({nwr, nrd, sv, busy}, {32'd0, sv, 32'd32, 1'b1})
    stall = 1'b0;
    wait_done(0);
    `CHK(nwr, 40)
    // Channel started behind a running one; lowest pending goes next
    cfg[0] = '{MEM_SBSRAM, MEM_INT, 1'b0, 2'h0, 16'h0004, 8'h02};
    cfg[1] = '{MEM_INT, MEM_SBSRAM, 1'b0, 2'h0, 16'h0003, 8'h01};
    clr();
    start(2'h0, START_RUN);
    start(2'h2, START_RUN);
    start(2'h1, START_RUN);
    wait_done(0);
    `CHK({nrd, flag[2:1]}, {32'd8, 2'b11})
    for (i = 0; i < 200 && rd_s !== 1'b1; i++) @(negedge mclk_in);
    if (i == 200) fails++;
    `CHK(rd_ch, 2'h1)
    wait_done(1);
    wait_done(2);
    `CHK(nwr, 13)
    // Reset in mid-transfer: all idle again, then a fresh transfer runs
    start(2'h0, START_RUN);
    repeat (20) @(negedge mclk_in);
    {sys_rst_in, exp_d} = {1'b1, 32'd0};
    repeat (2) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    `CHK({busy, flag, done, rd_s, wr_s}, 11'h000)
    clr();
    start(2'h3, START_RUN);
    wait_done(3);
    `CHK({nwr, rd_ch}, {32'd2, 2'h3})
    stop_test();
  end
endmodule
